// >>> bsjtag_tap.sv
// Boundary-scan TAP: instruction register and test data registers
`timescale 1ns/1ps
`include "bsjtag_params.svh"
// Function
// (RL1) Four-bit instruction register, sixteen codes
// (RL2) Instruction LSB shifts out to TDO first
// (RL3) Instruction shifts only in Shift-IR
// (RL4) Data registers parallel, instruction picks path
// (RL5) Instruction defines single shifted data register
// (RL6) Unselected registers leave system and path alone
// (RL7) Bypass is one stage, captures zero
// (RL8) Bypass leaves normal function untouched
// (RL9) Boundary register drives and samples pins
// (RL10) Read-only 32-bit identification register
// (RL11) Version, part, maker fields, bit0 one
// (RL12) Code 0 selects boundary register, EXTEST
// (RL13) Code 1 samples pins via boundary register
// (RL14) Code 1 preloads boundary update latches
// (RL15) Code 2 selects identification register
// (RL16) Code 3 floats all outputs
// (RL17) Code F selects bypass register
// (RL18) New instruction acts at Update-IR
// (RL19) Shift LSB first, TDO on falling edge
// (RL20) Five TMS-high cycles reach reset
// (RL21) Controller resets TAP after power-up
// (RL22) Unassigned codes act as bypass
// (RL23) Reset instruction is identification
module bsjtag_tap #(
  parameter int BSR_LEN = `BSJ_BSR_LEN,
  parameter logic [3:0] ID_VERSION = `BSJ_ID_VERSION,
  parameter logic [15:0] ID_PART = `BSJ_ID_PART,
  // Maker code value is arbitrary
  parameter logic [10:0] ID_MFR = `BSJ_ID_MFR
) (
  // System clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  // Test access pins
  input wire logic TEST_CLOCK_PIN,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TRSTN,
  output logic TDO,
  output logic TDO_OE,
  // Core pin boundary
  input wire logic [BSR_LEN-1:0] CORE_OUT,
  input wire logic [BSR_LEN-1:0] PIN_IN,
  output logic [BSR_LEN-1:0] PIN_OUT,
  output logic PIN_OE,
  // Status
  output logic [3:0] INSTRUCTION_BITS,
  output logic TAP_IN_RESET
);
  typedef struct packed {
    bsjtag_pkg::bsj_tap_t tap;
    logic tck_d;
    logic [3:0] ir_shift;
    logic [3:0] ir;
    logic byp;
    logic [BSR_LEN-1:0] bsr_shift;
    logic [BSR_LEN-1:0] bsr_upd;
    logic [`BSJ_ID_WIDTH-1:0] id_shift;
    logic tdo;
    logic tdo_oe;
    logic [2:0] ones;
  } bsj_state_t;

  logic [1:0] rst_sync;
  logic rst_n;
  logic tck_s, tms_s, tdi_s, trst_n_s;
  logic [3:0] sync_q;
  bsj_state_t st_reg, st_next;
  logic rise, fall;
  bsjtag_pkg::bsj_sel_t sel;

  // Reset release through two flops
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pins come from the tester's clock domain
  bsjtag_sync #(.WIDTH(4)) u_sync (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .ce(CE),
    .d({TEST_CLOCK_PIN, TMS, TDI, TRSTN}),
    .q(sync_q)
  );
  assign {tck_s, tms_s, tdi_s, trst_n_s} = sync_q;

  // Instruction to register selection, unknown codes bypass
  function automatic bsjtag_pkg::bsj_sel_t dec_sel(input logic [3:0] code);
    case (code)
      `BSJ_IR_EXTEST: dec_sel = bsjtag_pkg::BSJ_SEL_BSR; // RL12
      `BSJ_IR_SAMPLE: dec_sel = bsjtag_pkg::BSJ_SEL_BSR; // RL13
      `BSJ_IR_IDCODE: dec_sel = bsjtag_pkg::BSJ_SEL_ID; // RL15
      `BSJ_IR_BYPASS: dec_sel = bsjtag_pkg::BSJ_SEL_BYP; // RL17
      default: dec_sel = bsjtag_pkg::BSJ_SEL_BYP; // RL22
    endcase
  endfunction

  function automatic bsjtag_pkg::bsj_tap_t tap_step(input bsjtag_pkg::bsj_tap_t s,
                                                     input logic m);
    case (s)
      bsjtag_pkg::BSJ_RESET: tap_step = m ? bsjtag_pkg::BSJ_RESET : bsjtag_pkg::BSJ_IDLE;
      bsjtag_pkg::BSJ_IDLE: tap_step = m ? bsjtag_pkg::BSJ_SEL_DR : bsjtag_pkg::BSJ_IDLE;
      bsjtag_pkg::BSJ_SEL_DR: tap_step = m ? bsjtag_pkg::BSJ_SEL_IR : bsjtag_pkg::BSJ_CAP_DR;
      bsjtag_pkg::BSJ_CAP_DR: tap_step = m ? bsjtag_pkg::BSJ_EXIT1_DR : bsjtag_pkg::BSJ_SHIFT_DR;
      bsjtag_pkg::BSJ_SHIFT_DR: tap_step = m ? bsjtag_pkg::BSJ_EXIT1_DR : bsjtag_pkg::BSJ_SHIFT_DR;
      bsjtag_pkg::BSJ_EXIT1_DR: tap_step = m ? bsjtag_pkg::BSJ_UPD_DR : bsjtag_pkg::BSJ_PAUSE_DR;
      bsjtag_pkg::BSJ_PAUSE_DR: tap_step = m ? bsjtag_pkg::BSJ_EXIT2_DR : bsjtag_pkg::BSJ_PAUSE_DR;
      bsjtag_pkg::BSJ_EXIT2_DR: tap_step = m ? bsjtag_pkg::BSJ_UPD_DR : bsjtag_pkg::BSJ_SHIFT_DR;
      bsjtag_pkg::BSJ_UPD_DR: tap_step = m ? bsjtag_pkg::BSJ_SEL_DR : bsjtag_pkg::BSJ_IDLE;
      bsjtag_pkg::BSJ_SEL_IR: tap_step = m ? bsjtag_pkg::BSJ_RESET : bsjtag_pkg::BSJ_CAP_IR;
      bsjtag_pkg::BSJ_CAP_IR: tap_step = m ? bsjtag_pkg::BSJ_EXIT1_IR : bsjtag_pkg::BSJ_SHIFT_IR;
      bsjtag_pkg::BSJ_SHIFT_IR: tap_step = m ? bsjtag_pkg::BSJ_EXIT1_IR : bsjtag_pkg::BSJ_SHIFT_IR;
      bsjtag_pkg::BSJ_EXIT1_IR: tap_step = m ? bsjtag_pkg::BSJ_UPD_IR : bsjtag_pkg::BSJ_PAUSE_IR;
      bsjtag_pkg::BSJ_PAUSE_IR: tap_step = m ? bsjtag_pkg::BSJ_EXIT2_IR : bsjtag_pkg::BSJ_PAUSE_IR;
      bsjtag_pkg::BSJ_EXIT2_IR: tap_step = m ? bsjtag_pkg::BSJ_UPD_IR : bsjtag_pkg::BSJ_SHIFT_IR;
      bsjtag_pkg::BSJ_UPD_IR: tap_step = m ? bsjtag_pkg::BSJ_SEL_DR : bsjtag_pkg::BSJ_IDLE;
      default: tap_step = bsjtag_pkg::BSJ_RESET;
    endcase
  endfunction

  assign rise = tck_s && !st_reg.tck_d;
  assign fall = !tck_s && st_reg.tck_d;
  assign sel = dec_sel(st_reg.ir); // RL5

  always_comb begin
    st_next = st_reg;
    st_next.tck_d = tck_s;
    if (!trst_n_s) begin
      st_next.tap = bsjtag_pkg::BSJ_RESET;
      st_next.ir = `BSJ_IR_IDCODE; // RL23
      st_next.ones = 3'h0;
    end else if (rise) begin
      st_next.tap = tap_step(st_reg.tap, tms_s); // RL20
      // Counter only mirrors the walk to reset for checking
      if (!tms_s) begin
        st_next.ones = 3'h0;
      end else if (st_reg.ones != 3'h7) begin
        st_next.ones = st_reg.ones + 3'h1;
      end
      case (st_reg.tap)
        bsjtag_pkg::BSJ_RESET: begin
          st_next.ir = `BSJ_IR_IDCODE; // RL23
        end
        bsjtag_pkg::BSJ_CAP_IR: begin
          st_next.ir_shift = `BSJ_IR_CAPTURE;
        end
        bsjtag_pkg::BSJ_SHIFT_IR: begin
          st_next.ir_shift = {tdi_s, st_reg.ir_shift[3:1]}; // RL3
        end
        bsjtag_pkg::BSJ_UPD_IR: begin
          st_next.ir = st_reg.ir_shift; // RL18
        end
        bsjtag_pkg::BSJ_CAP_DR: begin
          // Only the selected register captures
          case (sel) // RL6
            bsjtag_pkg::BSJ_SEL_BSR: begin
              // Both boundary codes snapshot the pin side
              st_next.bsr_shift = PIN_IN; // RL12 RL13
            end
            bsjtag_pkg::BSJ_SEL_ID: begin
              st_next.id_shift = {ID_VERSION, ID_PART, ID_MFR, 1'b1}; // RL11
            end
            default: begin
              st_next.byp = 1'b0; // RL7
            end
          endcase
        end
        bsjtag_pkg::BSJ_SHIFT_DR: begin
          case (sel)
            bsjtag_pkg::BSJ_SEL_BSR: begin
              st_next.bsr_shift = {tdi_s, st_reg.bsr_shift[BSR_LEN-1:1]}; // RL9
            end
            bsjtag_pkg::BSJ_SEL_ID: begin
              st_next.id_shift = {tdi_s, st_reg.id_shift[`BSJ_ID_WIDTH-1:1]}; // RL10
            end
            default: begin
              st_next.byp = tdi_s; // RL7
            end
          endcase
        end
        bsjtag_pkg::BSJ_UPD_DR: begin
          if (sel == bsjtag_pkg::BSJ_SEL_BSR) begin
            st_next.bsr_upd = st_reg.bsr_shift; // RL14
          end
        end
        default: begin
          st_next.ones = st_next.ones;
        end
      endcase
    end else if (fall) begin
      // TDO moves on the falling edge, LSB first
      st_next.tdo_oe = (st_reg.tap == bsjtag_pkg::BSJ_SHIFT_IR) ||
                       (st_reg.tap == bsjtag_pkg::BSJ_SHIFT_DR); // RL19
      if (st_reg.tap == bsjtag_pkg::BSJ_SHIFT_IR) begin
        st_next.tdo = st_reg.ir_shift[0]; // RL2
      end else begin
        case (sel)
          bsjtag_pkg::BSJ_SEL_BSR: st_next.tdo = st_reg.bsr_shift[0]; // RL4
          bsjtag_pkg::BSJ_SEL_ID: st_next.tdo = st_reg.id_shift[0]; // RL4
          default: st_next.tdo = st_reg.byp; // RL4
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{tap: bsjtag_pkg::BSJ_RESET, ir: `BSJ_IR_IDCODE, default: '0};
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  // Core drives pins unless EXTEST owns them or code 3 floats them; bypass changes nothing
  always_comb begin
    PIN_OUT = CORE_OUT; // RL8
    PIN_OE = 1'b1;
    if (st_reg.ir == `BSJ_IR_EXTEST) begin
      PIN_OUT = st_reg.bsr_upd; // RL9
    end else if (st_reg.ir == `BSJ_IR_FLOAT) begin
      PIN_OE = 1'b0; // RL16
    end
  end

  assign TDO = st_reg.tdo;
  assign TDO_OE = st_reg.tdo_oe;
  assign INSTRUCTION_BITS = st_reg.ir; // RL1
  assign TAP_IN_RESET = (st_reg.tap == bsjtag_pkg::BSJ_RESET);

  property p_five_ones;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (CE && rise && st_reg.ones >= 3'h4 && tms_s) |=> TAP_IN_RESET;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("TAP not reset by TMS"); // RL20
  property p_upd_ir;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (CE && rise && trst_n_s && st_reg.tap == bsjtag_pkg::BSJ_UPD_IR) |=>
      (INSTRUCTION_BITS == $past(st_reg.ir_shift));
  endproperty
  a_upd_ir: assert property (p_upd_ir) else $error("Instruction not loaded"); // RL18
  property p_ir_hold;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (st_reg.tap != bsjtag_pkg::BSJ_UPD_IR && st_reg.tap != bsjtag_pkg::BSJ_RESET &&
       trst_n_s) |=> $stable(INSTRUCTION_BITS);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("Instruction changed early"); // RL3
  property p_byp_cap;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (CE && rise && trst_n_s && st_reg.tap == bsjtag_pkg::BSJ_CAP_DR &&
       sel == bsjtag_pkg::BSJ_SEL_BYP) |=> !st_reg.byp;
  endproperty
  a_byp_cap: assert property (p_byp_cap) else $error("Bypass did not capture zero"); // RL7
  property p_id_cap;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (CE && rise && trst_n_s && st_reg.tap == bsjtag_pkg::BSJ_CAP_DR &&
       sel == bsjtag_pkg::BSJ_SEL_ID) |=>
      (st_reg.id_shift[0] && st_reg.id_shift[31:28] == ID_VERSION);
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("Identification capture wrong"); // RL11
  property p_float;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (INSTRUCTION_BITS == `BSJ_IR_FLOAT) |-> !PIN_OE;
  endproperty
  a_float: assert property (p_float) else $error("Outputs not floated"); // RL16
  property p_byp_pins;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (INSTRUCTION_BITS == `BSJ_IR_BYPASS) |-> (PIN_OUT == CORE_OUT && PIN_OE);
  endproperty
  a_byp_pins: assert property (p_byp_pins) else $error("Bypass disturbed pins"); // RL8
  property p_tdo_fall;
    @(posedge CLK_SYS) disable iff (!rst_n)
      !(CE && fall) |=> $stable(TDO);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("TDO moved off a fall"); // RL19
  property p_trst;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (CE && !trst_n_s) |=> (TAP_IN_RESET && INSTRUCTION_BITS == `BSJ_IR_IDCODE);
  endproperty
  a_trst: assert property (p_trst) else $error("Test reset lost identification"); // RL23
  property p_ir_shift;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (CE && rise && trst_n_s && st_reg.tap == bsjtag_pkg::BSJ_SHIFT_IR) |=>
      (st_reg.ir_shift[3] == $past(tdi_s));
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("Instruction bit not taken"); // RL3
  property p_tdo_ir;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (CE && fall && trst_n_s && st_reg.tap == bsjtag_pkg::BSJ_SHIFT_IR) |=>
      (TDO == $past(st_reg.ir_shift[0]));
  endproperty
  a_tdo_ir: assert property (p_tdo_ir) else $error("Instruction LSB not on TDO"); // RL2
  property p_oe_shift;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (CE && fall && trst_n_s) |=>
      (TDO_OE == ($past(st_reg.tap) == bsjtag_pkg::BSJ_SHIFT_IR ||
                  $past(st_reg.tap) == bsjtag_pkg::BSJ_SHIFT_DR));
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("TDO enable wrong"); // RL19
  property p_bsr_cap;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (CE && rise && trst_n_s && st_reg.tap == bsjtag_pkg::BSJ_CAP_DR &&
       sel == bsjtag_pkg::BSJ_SEL_BSR) |=> (st_reg.bsr_shift == $past(PIN_IN));
  endproperty
  a_bsr_cap: assert property (p_bsr_cap) else $error("Pins not captured"); // RL13
  property p_unsel_id;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (sel != bsjtag_pkg::BSJ_SEL_ID) |=> $stable(st_reg.id_shift);
  endproperty
  a_unsel_id: assert property (p_unsel_id) else $error("Idle identity moved"); // RL6
  property p_unsel_bsr;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (sel != bsjtag_pkg::BSJ_SEL_BSR) |=>
      ($stable(st_reg.bsr_shift) && $stable(st_reg.bsr_upd));
  endproperty
  a_unsel_bsr: assert property (p_unsel_bsr) else $error("Idle boundary moved"); // RL6
  property p_code_byp;
    @(posedge CLK_SYS) disable iff (!rst_n)
      !(INSTRUCTION_BITS inside {`BSJ_IR_EXTEST, `BSJ_IR_SAMPLE, `BSJ_IR_IDCODE}) |->
      (sel == bsjtag_pkg::BSJ_SEL_BYP);
  endproperty
  a_code_byp: assert property (p_code_byp) else $error("Code not on bypass"); // RL22
  property p_code_id;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (INSTRUCTION_BITS == `BSJ_IR_IDCODE) |-> (sel == bsjtag_pkg::BSJ_SEL_ID);
  endproperty
  a_code_id: assert property (p_code_id) else $error("Identity not selected"); // RL15
  property p_code_bsr;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (INSTRUCTION_BITS inside {`BSJ_IR_EXTEST, `BSJ_IR_SAMPLE}) |->
      (sel == bsjtag_pkg::BSJ_SEL_BSR);
  endproperty
  a_code_bsr: assert property (p_code_bsr) else $error("Boundary not selected"); // RL12
  property p_ext_pins;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (INSTRUCTION_BITS == `BSJ_IR_EXTEST) |-> (PIN_OUT == st_reg.bsr_upd);
  endproperty
  a_ext_pins: assert property (p_ext_pins) else $error("Pins not from latches"); // RL9
endmodule

// >>> bsjtag_params.svh
// Constants for the boundary-scan test logic
`ifndef BSJTAG_PARAMS_SVH
`define BSJTAG_PARAMS_SVH
`define BSJ_IR_WIDTH 4
`define BSJ_IR_EXTEST 4'h0
`define BSJ_IR_SAMPLE 4'h1
`define BSJ_IR_IDCODE 4'h2
`define BSJ_IR_FLOAT 4'h3
`define BSJ_IR_BYPASS 4'hF
`define BSJ_IR_CAPTURE 4'h1
`define BSJ_ID_WIDTH 32
`define BSJ_ID_VER_LSB 28
`define BSJ_ID_PART_LSB 12
`define BSJ_ID_MFR_LSB 1
`define BSJ_ID_VERSION 4'h0
`define BSJ_ID_PART 16'h1234
`define BSJ_ID_MFR 11'h055
`define BSJ_BSR_LEN 8
`define BSJ_TLR_ONES 5
`endif

// >>> bsjtag_pkg.sv
// Types for the boundary-scan test logic
package bsjtag_pkg;
  typedef enum logic [3:0] {
    BSJ_RESET = 4'h0,
    BSJ_IDLE = 4'h1,
    BSJ_SEL_DR = 4'h3,
    BSJ_CAP_DR = 4'h2,
    BSJ_SHIFT_DR = 4'h6,
    BSJ_EXIT1_DR = 4'h7,
    BSJ_PAUSE_DR = 4'h5,
    BSJ_EXIT2_DR = 4'h4,
    BSJ_UPD_DR = 4'hC,
    BSJ_SEL_IR = 4'hD,
    BSJ_CAP_IR = 4'hF,
    BSJ_SHIFT_IR = 4'hE,
    BSJ_EXIT1_IR = 4'hA,
    BSJ_PAUSE_IR = 4'hB,
    BSJ_EXIT2_IR = 4'h9,
    BSJ_UPD_IR = 4'h8
  } bsj_tap_t;

  typedef enum logic [1:0] {
    BSJ_SEL_BYP = 2'h0,
    BSJ_SEL_BSR = 2'h1,
    BSJ_SEL_ID = 2'h2
  } bsj_sel_t;
endpackage

// >>> bsjtag_sync.sv
// Two-stage synchroniser for TAP pins
`timescale 1ns/1ps
module bsjtag_sync #(
  parameter int WIDTH = 4
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// >>> bsjtag_ctl.sv
// Test controller model that drives the TAP pins
`timescale 1ns/1ps
module bsjtag_ctl (
  // Clock
  input wire logic clk,
  // Pins toward the device
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  // Scan results
  output logic [31:0] res,
  output logic res_vld
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
    res = 32'h0;
    res_vld = 1'b0;
  end

  // One test-clock period of eight system cycles; clock rests low between frames
  task automatic cyc(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    // Sampled just before the rise, at least one system cycle after TDO settled
    q = tdo;
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    tck <= 1'b0;
  endtask

  // Unused serial data toggles so a stale level is never mistaken for data
  task automatic idle_cyc(input logic m);
    logic q;
    cyc(m, ~tdi, q);
  endtask

  task automatic tms_reset();
    repeat (5) idle_cyc(1'b1);
    idle_cyc(1'b0);
  endtask

  task automatic pulse_trst();
    trst_n <= 1'b0;
    // Longer than the synchroniser depth
    repeat (4) @(posedge clk);
    trst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // From Idle: scan n bits LSB first, back to Idle, then post the result
  task automatic scan(input logic ir, input int n, input logic [31:0] din);
    logic [31:0] dout;
    logic q;
    dout = 32'h0;
    idle_cyc(1'b1);
    if (ir) idle_cyc(1'b1);
    idle_cyc(1'b0);
    idle_cyc(1'b0);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], q);
      dout[i] = q;
    end
    idle_cyc(1'b1);
    idle_cyc(1'b0);
    res <= dout;
    res_vld <= 1'b1;
    @(posedge clk);
    res_vld <= 1'b0;
  endtask
endmodule

// >>> bsjtag_tap_tb.sv
// Self-checking bench for the boundary-scan TAP
`timescale 1ns/1ps
`include "bsjtag_params.svh"
`define BSJ_CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module bsjtag_tap_tb;
  localparam logic [31:0] ID_EXP = {`BSJ_ID_VERSION, `BSJ_ID_PART, `BSJ_ID_MFR, 1'b1};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic tck, tms, tdi, trstn, tdo, tdo_oe, pin_oe, tap_rst, res_vld;
  logic [7:0] core_out = 8'h00;
  logic [7:0] pin_in = 8'h00;
  logic [7:0] pin_out;
  logic [3:0] ir_bits;
  logic [31:0] res, e_v, m_v;
  int failures = 0;
  int cmp_count = 0;
  int oe_cycles = 0;
  int seed = 32'h3f5d5f8c;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];

  always #50 clk_sys = ~clk_sys;

  bsjtag_tap i_bsjtag_tap (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .TEST_CLOCK_PIN(tck), .TMS(tms), .TDI(tdi),
    .TRSTN(trstn), .TDO(tdo), .TDO_OE(tdo_oe), .CORE_OUT(core_out), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .INSTRUCTION_BITS(ir_bits), .TAP_IN_RESET(tap_rst)
  );
  bsjtag_ctl i_bsjtag_ctl (
    .clk(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trstn), .tdo(tdo),
    .res(res), .res_vld(res_vld)
  );

  task automatic push(input logic [31:0] e, input logic [31:0] m);
    q_exp.push_back(e);
    q_msk.push_back(m);
  endtask

  // Oldest note is matched against each posted scan result
  always @(posedge clk_sys) begin
    if (res_vld === 1'b1) begin
      if (q_exp.size() == 0) begin
        failures++;
        $display("[FAIL] scan note expected present seen none");
      end else begin
        e_v = q_exp.pop_front();
        m_v = q_msk.pop_front();
        `BSJ_CHK("scan out", e_v & m_v, res & m_v)
      end
    end
  end

  // Enable must stand for exactly the shifted bits
  always @(posedge clk_sys) begin
    if (tdo_oe === 1'b1) oe_cycles++;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    logic [31:0] din;
    logic [7:0] pre;
    logic [3:0] code;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `BSJ_CHK("ir at reset", 4'h2, ir_bits)
    i_bsjtag_ctl.tms_reset();
    `BSJ_CHK("left reset", 1'b0, tap_rst)
    // Second read shifts other data in; the identity must not change
    repeat (2) begin
      push(ID_EXP, 32'hFFFFFFFF);
      i_bsjtag_ctl.scan(1'b0, 32, $random(seed));
    end
    // Five ones from Shift-DR, the farthest case
    i_bsjtag_ctl.idle_cyc(1'b1);
    i_bsjtag_ctl.idle_cyc(1'b0);
    i_bsjtag_ctl.idle_cyc(1'b0);
    repeat (4) i_bsjtag_ctl.idle_cyc(1'b1);
    `BSJ_CHK("four ones", 1'b0, tap_rst)
    i_bsjtag_ctl.idle_cyc(1'b1);
    `BSJ_CHK("five ones", 1'b1, tap_rst)
    i_bsjtag_ctl.idle_cyc(1'b0);
    // Preload first so the switch to external test has a known pattern
    pre = 8'h00;
    for (int i = 0; i < 16; i++) begin
      code = (i == 0) ? 4'h1 : (i == 1) ? 4'h0 : 4'(i);
      push(32'h1, 32'hF);
      i_bsjtag_ctl.scan(1'b1, 4, {28'h0, code});
      `BSJ_CHK("instruction", code, ir_bits)
      `BSJ_CHK("pin enable", code != 4'h3, pin_oe)
      if (code == 4'h0) `BSJ_CHK("preloaded pins", pre, pin_out)
      core_out <= 8'($random(seed));
      pin_in <= 8'($random(seed));
      din = $random(seed);
      @(posedge clk_sys);
      case (code)
        4'h0, 4'h1: push({24'h0, pin_in}, 32'hFF);
        4'h2: push(ID_EXP, 32'hFF);
        default: push({24'h0, din[6:0], 1'b0}, 32'hFF);
      endcase
      i_bsjtag_ctl.scan(1'b0, 8, din);
      `BSJ_CHK("pin out", (code == 4'h0) ? din[7:0] : core_out, pin_out)
      if (code == 4'h1) pre = din[7:0];
    end
    i_bsjtag_ctl.pulse_trst();
    `BSJ_CHK("ir after trst", 4'h2, ir_bits)
    `BSJ_CHK("reset after trst", 1'b1, tap_rst)
    // Frozen logic must miss a whole test-clock pulse
    ce <= 1'b0;
    i_bsjtag_ctl.idle_cyc(1'b0);
    ce <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `BSJ_CHK("frozen", 1'b1, tap_rst)
    i_bsjtag_ctl.idle_cyc(1'b0);
    push(ID_EXP, 32'hFFFFFFFF);
    oe_cycles = 0;
    i_bsjtag_ctl.scan(1'b0, 32, $random(seed));
    `BSJ_CHK("oe cycles", 32 * 8, oe_cycles)
    repeat (4) @(posedge clk_sys);
    print_verdict();
  end

  // About five times the expected length of the run
  initial begin
    #2000000;
    failures++;
    $display("[FAIL] watchdog expected done seen hang");
    print_verdict();
  end
endmodule
